// [core/bldcsl_pkg.sv]
// Constants, register map and carrier types of the brushless speed loop.
// Assumes a 50 MHz system clock and a reference clock sampled as a plain input.
package bldcsl_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned LOCKP_TIME_MS = 3300;
	localparam int unsigned LOCKP_CYCLES = (CLK_HZ / 1000) * LOCKP_TIME_MS;
	localparam logic [3:0]  PWM_PRE_MAX  = 4'h9;   // 50 MHz / 10 / 256 gives about 19.5 kHz.
	// ----------------------------------------------------------------
	// Speed loop figures
	// ----------------------------------------------------------------
	localparam logic [11:0] TGT_CNT  = 12'h200;   // Reference edges per tacho period (divide by 512).
	localparam logic [11:0] LOCK_WIN = 12'h020;   // 6.25 percent of 512.
	localparam logic [11:0] CNT_MAX  = 12'hFFF;
	localparam logic [7:0]  DUTY_MAX = 8'hFF;
	localparam logic [7:0]  DUTY_RST = 8'h80;
	localparam logic [7:0]  PWM_END  = 8'hFF;
	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PERIOD = 8'h08;
	localparam logic [7:0] REG_DUTY   = 8'h0C;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_STEP_LO = 8;
	localparam logic [3:0] CTRL_STEP_RST = 4'h4;
	localparam int PER_PHASE_LO = 16;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] hi;   // Upper switches, phases C B A.
		logic [2:0] lo;   // Lower switches, chopped by the PWM.
	} bldcsl_drive_t;

	typedef struct packed {
		logic        por_done;
		logic [2:0]  hall;
		logic        tacho;
		logic        ref_clk;
		logic [11:0] cnt;
		logic [11:0] meas;
		logic        pair;
		logic        disc;
		logic        locked;
		logic [8:0]  phase_div;
		logic [8:0]  phase_err;
		logic [7:0]  duty;
		logic [3:0]  pre;
		logic [7:0]  pwm_cnt;
		logic        oc;
		logic [31:0] lockp_cnt;
		logic        trip;
		logic        ctrl_run;
		logic [3:0]  ctrl_step;
		logic        bus_act;
		logic        bus_wr;
		logic [7:0]  bus_addr;
		logic [31:0] rdata;
		bldcsl_drive_t drv;
	} bldcsl_state_t;
endpackage : bldcsl_pkg

// [core/bldcsl_core.sv]
// Speed loop, commutation, PWM and protection logic of a three-phase motor driver.
// Assumes all pins synchronous to mclk_i and a single AHB-Lite master on the register bus.
`timescale 1ns/10ps
`default_nettype none
module bldcsl_core #(
	parameter int unsigned LOCKP_CYCLES = bldcsl_pkg::LOCKP_CYCLES
) (
	input  wire logic                  mclk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  hall_a_pos_i,
	input  wire logic                  hall_a_neg_i,
	input  wire logic                  hall_b_pos_i,
	input  wire logic                  hall_b_neg_i,
	input  wire logic                  hall_c_pos_i,
	input  wire logic                  hall_c_neg_i,
	input  wire logic                  tacho_in_pos_i,
	input  wire logic                  tacho_in_neg_i,
	input  wire logic                  ref_clock_in_i,
	input  wire logic                  run_pin_i,
	input  wire logic                  run_pin_conn_i,
	input  wire logic                  dir_pin_i,
	input  wire logic                  dir_pin_conn_i,
	input  wire logic                  overcurrent_i,
	input  wire logic                  hsel_i,
	input  wire logic [31:0]           haddr_i,
	input  wire logic [1:0]            htrans_i,
	input  wire logic                  hwrite_i,
	input  wire logic [2:0]            hsize_i,
	input  wire logic [31:0]           hwdata_i,
	input  wire logic                  hready_i,
	output logic                       hreadyout_o,
	output logic                       hresp_o,
	output logic [31:0]                hrdata_o,
	output bldcsl_pkg::bldcsl_drive_t  drive_o,
	output logic                       speed_disc_o,
	output logic                       speed_lock_flag_o,
	output logic                       speed_lock_flag_oe_o,
	output logic                       tacho_amp_out_o,
	output logic                       bias_en_o,
	output logic                       regulator_out_en_o
);
	bldcsl_pkg::bldcsl_state_t q;
	bldcsl_pkg::bldcsl_state_t nxt_q;
	logic [2:0] hall_pos;
	logic [2:0] hall_neg;
	logic       run_eff;
	logic       fwd;
	logic       tacho_rise;
	logic       tacho_dec;
	logic       ref_rise;
	logic       pwm_tick;
	logic [11:0] err;
	logic [8:0]  duty_wide;
	logic        meas_slow;

	assign hall_pos = {hall_c_pos_i, hall_b_pos_i, hall_a_pos_i};
	assign hall_neg = {hall_c_neg_i, hall_b_neg_i, hall_a_neg_i};
	// An open control pin floats to the internal pull-up level.
	assign run_eff = (run_pin_conn_i ? run_pin_i : 1'b1) & q.ctrl_run;
	assign fwd     = dir_pin_conn_i ? dir_pin_i : 1'b1;
	assign tacho_dec  = (tacho_in_pos_i != tacho_in_neg_i) ? tacho_in_pos_i : q.tacho; // Equal inputs hold the level.
	assign tacho_rise = tacho_dec & ~q.tacho;
	assign ref_rise   = ref_clock_in_i & ~q.ref_clk;
	assign pwm_tick   = (q.pre == bldcsl_pkg::PWM_PRE_MAX);
	assign meas_slow  = (q.meas > bldcsl_pkg::TGT_CNT);

	// ----------------------------------------------------------------
	// Commutation table
	// ----------------------------------------------------------------
	// Reverse rotation swaps which phase is sourced and which is sunk.
	function automatic bldcsl_pkg::bldcsl_drive_t commutate(input logic [2:0] code, input logic dir_fwd);
		bldcsl_pkg::bldcsl_drive_t d;
		d = '0;
		case (code)
			3'h5: d = '{hi: 3'h1, lo: 3'h2};
			3'h4: d = '{hi: 3'h1, lo: 3'h4};
			3'h6: d = '{hi: 3'h2, lo: 3'h4};
			3'h2: d = '{hi: 3'h2, lo: 3'h1};
			3'h3: d = '{hi: 3'h4, lo: 3'h1};
			3'h1: d = '{hi: 3'h4, lo: 3'h2};
			default: d = '0;
		endcase
		if (!dir_fwd) begin
			d = '{hi: d.lo, lo: d.hi};
		end
		return d;
	endfunction : commutate

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// One process computes the whole next state; the flop below only registers it.
	always_comb begin
		nxt_q = q;
		err = '0;
		duty_wide = '0;
		// Comparator inputs: an equal pair keeps the last level, acting as hysteresis.
		for (int i = 0; i < 3; i++) begin
			if (hall_pos[i] && !hall_neg[i]) begin
				nxt_q.hall[i] = 1'b1;
			end else if (!hall_pos[i] && hall_neg[i]) begin
				nxt_q.hall[i] = 1'b0;
			end
		end
		nxt_q.tacho = tacho_dec;
		nxt_q.ref_clk = ref_clock_in_i;
		// The start-up capacitor charges until the positive tacho input is first seen high.
		if (tacho_in_pos_i) begin
			nxt_q.por_done = 1'b1;
		end
		// Reference divider by 512 sets the target tacho phase.
		if (ref_rise) begin
			nxt_q.phase_div = q.phase_div + 9'h001;
			if (q.cnt != bldcsl_pkg::CNT_MAX) begin
				nxt_q.cnt = q.cnt + 12'h001;
			end
		end
		// Speed and phase loops act on tacho edges only.
		if (tacho_rise && q.por_done) begin
			nxt_q.cnt = '0;
			nxt_q.pair = ~q.pair;
			nxt_q.phase_err = q.phase_div;
			duty_wide = {1'b0, q.duty};
			if (!q.pair) begin
				nxt_q.meas = (ref_rise && q.cnt != bldcsl_pkg::CNT_MAX) ? q.cnt + 12'h001 : q.cnt;
			end else begin
				err = meas_slow ? q.meas - bldcsl_pkg::TGT_CNT : bldcsl_pkg::TGT_CNT - q.meas;
				nxt_q.disc = meas_slow;
				nxt_q.locked = (err <= bldcsl_pkg::LOCK_WIN);
				if (err > bldcsl_pkg::LOCK_WIN) begin
					duty_wide = meas_slow ? duty_wide + {5'h00, q.ctrl_step} : duty_wide - {5'h00, q.ctrl_step};
				end
			end
			// The phase trim only acts once the speed is in the window.
			if (q.locked && !(q.pair && err > bldcsl_pkg::LOCK_WIN)) begin
				duty_wide = q.phase_div[8] ? duty_wide - 9'h001 : duty_wide + 9'h001;
			end
			if (duty_wide[8]) begin
				nxt_q.duty = (meas_slow || !q.phase_div[8]) ? bldcsl_pkg::DUTY_MAX : 8'h00;
			end else begin
				nxt_q.duty = duty_wide[7:0];
			end
		end
		// PWM carrier; the overcurrent latch ends with the carrier cycle, but a new trip wins.
		nxt_q.pre = pwm_tick ? 4'h0 : q.pre + 4'h1;
		if (pwm_tick) begin
			nxt_q.pwm_cnt = q.pwm_cnt + 8'h01;
			if (q.pwm_cnt == bldcsl_pkg::PWM_END) begin
				nxt_q.oc = 1'b0;
			end
		end
		if (overcurrent_i) begin
			nxt_q.oc = 1'b1;
		end
		// Lock protection counts unlocked run time and latches until stop.
		if (run_eff && q.por_done) begin
			if (!q.locked && !q.trip) begin
				nxt_q.lockp_cnt = q.lockp_cnt + 32'h1;
				if (q.lockp_cnt >= LOCKP_CYCLES - 1) begin
					nxt_q.trip = 1'b1;
				end
			end else if (q.locked) begin
				nxt_q.lockp_cnt = '0;
			end
		end else begin
			nxt_q.lockp_cnt = '0;
			nxt_q.trip = 1'b0;
			nxt_q.locked = 1'b0;
			nxt_q.pair = 1'b0;
		end
		// Drive: upper switch steady, lower switch chopped by duty, cut by overcurrent and trip.
		nxt_q.drv = '0;
		if (run_eff && q.por_done) begin
			nxt_q.drv = commutate(nxt_q.hall, fwd);
			if (nxt_q.oc || nxt_q.trip || !(q.pwm_cnt < q.duty)) begin
				nxt_q.drv.lo = '0;
			end
		end
		// AHB-Lite: address phase is captured, data phase writes; no wait states.
		if (q.bus_act && q.bus_wr && q.bus_addr == bldcsl_pkg::REG_CTRL) begin
			nxt_q.ctrl_run  = hwdata_i[bldcsl_pkg::CTRL_RUN_BIT];
			nxt_q.ctrl_step = hwdata_i[bldcsl_pkg::CTRL_STEP_LO +: 4];
		end
		nxt_q.bus_act  = hsel_i && htrans_i[1] && hready_i;
		nxt_q.bus_wr   = hwrite_i;
		nxt_q.bus_addr = haddr_i[7:0];
		nxt_q.rdata    = '0;
		if (hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[31:8] == 24'h000000) begin
			case (haddr_i[7:0])
				bldcsl_pkg::REG_CTRL:   nxt_q.rdata = {20'h00000, q.ctrl_step, 7'h00, q.ctrl_run};
				bldcsl_pkg::REG_STATUS: nxt_q.rdata = {24'h000000, run_eff, q.hall, q.oc, q.trip, q.disc, q.locked};
				bldcsl_pkg::REG_PERIOD: nxt_q.rdata = {7'h00, q.phase_err, 4'h0, q.meas};
				bldcsl_pkg::REG_DUTY:   nxt_q.rdata = {24'h000000, q.duty};
				default:                nxt_q.rdata = '0;
			endcase
		end
		// Without the start-up charge the loop state, all but the reference divider, is held at its initial value.
		if (!q.por_done) begin
			nxt_q.cnt = '0;
			nxt_q.duty = bldcsl_pkg::DUTY_RST;
			nxt_q.trip = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			q.duty <= bldcsl_pkg::DUTY_RST;
			q.ctrl_run <= 1'b1;
			q.ctrl_step <= bldcsl_pkg::CTRL_STEP_RST;
		end else begin
			q <= nxt_q;
		end
	end

	// Outputs; the lock flag is open drain, pulled low only while locked.
	assign hreadyout_o          = 1'b1;
	assign hresp_o              = 1'b0;
	assign hrdata_o             = q.rdata;
	assign drive_o              = q.drv;
	assign speed_disc_o         = q.disc;
	assign speed_lock_flag_o    = 1'b0;
	assign speed_lock_flag_oe_o = q.locked;
	assign tacho_amp_out_o      = q.tacho;
	assign bias_en_o            = run_eff;
	assign regulator_out_en_o   = 1'b1;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	property p_disc;
		tacho_rise && q.pair && q.por_done && run_eff |=> speed_disc_o == $past(meas_slow);
	endproperty
	a_disc: assert property (p_disc) else $error("Discriminator result wrong.");

	property p_lock_pin;
		tacho_rise && q.pair && q.por_done && run_eff |=> !speed_lock_flag_o && speed_lock_flag_oe_o ==
			($past(q.meas) >= bldcsl_pkg::TGT_CNT - bldcsl_pkg::LOCK_WIN &&
			 $past(q.meas) <= bldcsl_pkg::TGT_CNT + bldcsl_pkg::LOCK_WIN);
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("Lock flag not pulled low.");

	property p_por;
		!q.por_done |=> drive_o == '0;
	endproperty
	a_por: assert property (p_por) else $error("Drive active before start-up.");

	property p_hall;
		hall_b_pos_i && !hall_b_neg_i |=> q.hall[1];
	endproperty
	a_hall: assert property (p_hall) else $error("Hall decode wrong.");

	property p_pair;
		tacho_rise && !q.pair && q.por_done && run_eff && !ref_rise |=> q.meas == $past(q.cnt);
	endproperty
	a_pair: assert property (p_pair) else $error("Period not measured.");

	property p_phase;
		tacho_rise && q.por_done |=> q.phase_err == $past(q.phase_div);
	endproperty
	a_phase: assert property (p_phase) else $error("Phase error not taken.");

	property p_chop;
		drive_o.lo != 3'h0 |-> (drive_o.hi != 3'h0) && ((drive_o.hi & drive_o.lo) == 3'h0);
	endproperty
	a_chop: assert property (p_chop) else $error("Lower switch on without upper.");

	property p_oc;
		overcurrent_i |=> drive_o.lo == 3'h0 [*2];
	endproperty
	a_oc: assert property (p_oc) else $error("Overcurrent did not cut the drive.");

	property p_trip;
		q.trip && run_eff |=> q.trip && drive_o.lo == 3'h0;
	endproperty
	a_trip: assert property (p_trip) else $error("Lock trip released in run.");

	property p_stop;
		!run_eff |=> !q.trip && drive_o == '0 && regulator_out_en_o;
	endproperty
	a_stop: assert property (p_stop) else $error("Stop mode left drive on.");
endmodule : bldcsl_core
`default_nettype wire

// [test/bldcsl_partner.sv]
// Far-side model: Hall sensors, tacho sensor and reference clock source.
// Assumes the bench sets per_i before each long period and the Hall code at will.
`timescale 1ns/10ps
`default_nettype none
module bldcsl_partner (
	input  wire logic        mclk_i,
	input  wire logic        en_i,
	input  wire logic [11:0] per_i,
	input  wire logic [2:0]  hall_i,
	output logic [2:0]       hall_pos_o,
	output logic [2:0]       hall_neg_o,
	output logic             tacho_pos_o,
	output logic             tacho_neg_o,
	output logic             ref_o,
	output logic             edge_o
);
	logic lng;
	// ----------------------------------------------------------------
	// Sensors and clock
	// ----------------------------------------------------------------
	// Differential pairs always disagree, so the decoded level is never held.
	assign hall_pos_o = hall_i;
	assign hall_neg_o = ~hall_i;
	assign tacho_neg_o = ~tacho_pos_o;
	// One reference period is 50 system cycles, the fastest rate allowed.
	initial ref_o = 1'b0;
	always begin
		repeat (25) @(posedge mclk_i);
		ref_o <= ~ref_o;
	end
	// Long measured periods alternate with short unmeasured ones to save run time.
	initial begin
		tacho_pos_o = 1'b0;
		edge_o = 1'b0;
		lng = 1'b1;
		wait (en_i);
		forever begin
			@(posedge mclk_i);
			tacho_pos_o <= 1'b1;
			edge_o <= 1'b1;
			@(posedge mclk_i);
			edge_o <= 1'b0;
			repeat (4) @(posedge ref_o);
			@(posedge mclk_i);
			tacho_pos_o <= 1'b0;
			repeat (lng ? int'(per_i) - 5 : 12) @(posedge ref_o);
			lng = ~lng;
		end
	end
endmodule : bldcsl_partner
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the brushless speed loop core.
// Assumes a zero-wait AHB-Lite slave and the far-side model in bldcsl_partner.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,g) begin n_checks++; if ((g)!==(e)) begin $display("ERROR %s exp %0h got %0h",n,e,g); fail_count++; end end
module tb_top;
	logic mclk_i = 1'b0, arst_n = 1'b0, en = 1'b0, oc = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic run_pin = 1'b1, run_conn = 1'b1, dir_pin = 1'b1, dir_conn = 1'b1;
	logic [11:0] per = 12'h000;
	logic [2:0] hall = 3'h0, hp, hn;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hready, tp, tn, rclk, edge_s, disc, loe, bias, regen, ok, tamp, hresp, lflag;
	bldcsl_pkg::bldcsl_drive_t drv;
	int fail_count = 0, n_checks = 0, d_prev, p, ph, ref_n = 0;
	int per_q[$] = '{440, 512, 584};
	always #10 mclk_i = ~mclk_i;
	// Bench model of the reference divider: every reference rise since start.
	always @(posedge rclk) ref_n++;
	// ----------------------------------------------------------------
	// Design and far side
	// ----------------------------------------------------------------
	bldcsl_core #(.LOCKP_CYCLES(6000)) DUT (.mclk_i(mclk_i), .arst_n_i(arst_n),
		.hall_a_pos_i(hp[0]), .hall_a_neg_i(hn[0]), .hall_b_pos_i(hp[1]), .hall_b_neg_i(hn[1]),
		.hall_c_pos_i(hp[2]), .hall_c_neg_i(hn[2]), .tacho_in_pos_i(tp), .tacho_in_neg_i(tn),
		.ref_clock_in_i(rclk), .run_pin_i(run_pin), .run_pin_conn_i(run_conn), .dir_pin_i(dir_pin),
		.dir_pin_conn_i(dir_conn), .overcurrent_i(oc), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(hresp), .hrdata_o(hrdata), .drive_o(drv), .speed_disc_o(disc), .speed_lock_flag_o(lflag),
		.speed_lock_flag_oe_o(loe), .tacho_amp_out_o(tamp), .bias_en_o(bias), .regulator_out_en_o(regen));
	bldcsl_partner u_far (.mclk_i(mclk_i), .en_i(en), .per_i(per), .hall_i(hall), .hall_pos_o(hp),
		.hall_neg_o(hn), .tacho_pos_o(tp), .tacho_neg_o(tn), .ref_o(rclk), .edge_o(edge_s));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic results();
		if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// Every wait is bounded; running out counts as a mismatch and ends the run.
	task automatic wait_for(input int lim, input int kind);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge mclk_i);
			if ((kind == 0 && hready === 1'b1) || (kind == 1 && edge_s === 1'b1)) break;
			if (kind == 2 && drv.lo === 3'h2) break;
		end
		if (i == lim) begin
			fail_count++;
			results();
		end
	endtask : wait_for
	// One single AHB-Lite word transfer; read data is taken at the end of the data phase.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_for(100, 0);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_for(100, 0);
		rd = hrdata;
	endtask : ahb
	// Expected switch pattern {hi, lo}; reverse swaps upper and lower sets.
	function automatic logic [5:0] exp_drv(input logic [2:0] h, input logic fwd);
		logic [5:0] v;
		case (h)
			3'h5: v = 6'h0A;
			3'h4: v = 6'h0C;
			3'h6: v = 6'h14;
			3'h2: v = 6'h11;
			3'h3: v = 6'h21;
			3'h1: v = 6'h22;
			default: v = 6'h00;
		endcase
		return fwd ? v : {v[2:0], v[5:3]};
	endfunction : exp_drv
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(48720));
		repeat (16) @(posedge mclk_i);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk_i);
		`CHK("drive_hold", 6'h00, drv);
		ahb(1'b0, bldcsl_pkg::REG_CTRL, 32'h0);
		`CHK("ctrl_rst", 32'h00000401, rd);
		`CHK("hresp", 1'b0, hresp);
		ahb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h00000000, rd);
		run_pin <= 1'b0;
		repeat (2) @(posedge mclk_i);
		`CHK("bias_stop", 1'b0, bias);
		run_pin <= 1'($urandom);
		run_conn <= 1'b0;
		repeat (2) @(posedge mclk_i);
		`CHK("bias_open", 1'b1, bias);
		per <= 12'(per_q[0]);
		en <= 1'b1;
		wait_for(200, 1);
		// A stop right after the first tacho edge lines the pair counter up.
		repeat (3) @(posedge mclk_i);
		`CHK("tacho_amp", 1'b1, tamp);
		ahb(1'b1, bldcsl_pkg::REG_CTRL, 32'h00000400);
		@(posedge mclk_i); // CTRL lands at the edge that ends the data phase.
		`CHK("bias_ps", 1'b0, bias);
		`CHK("reg_on", 1'b1, regen);
		ahb(1'b1, bldcsl_pkg::REG_CTRL, 32'h00000401);
		for (int d = 0; d < 2; d++) begin
			for (int h = 0; h < 8; h++) begin
				dir_conn <= 1'(1 - d);
				dir_pin <= d ? 1'($urandom) : 1'b0;
				hall <= 3'(h);
				repeat (4) @(posedge mclk_i);
				`CHK("hi", exp_drv(3'(h), 1'(d))>>3, 6'(drv.hi));
				`CHK("lo_mask", 3'h0, drv.lo & ~exp_drv(3'(h), 1'(d)));
				ahb(1'b0, bldcsl_pkg::REG_STATUS, 32'h0);
				`CHK("hall", 3'(h), rd[6:4]);
			end
		end
		hall <= 3'h5;
		wait_for(3000, 2);
		oc <= 1'b1;
		@(posedge mclk_i);
		oc <= 1'b0;
		repeat (2) @(posedge mclk_i);
		ok = 1'b1;
		repeat (50) begin
			@(posedge mclk_i);
			if (drv.lo !== 3'h0) ok = 1'b0;
		end
		`CHK("oc_blank", 1'b1, ok);
		ahb(1'b0, bldcsl_pkg::REG_STATUS, 32'h0);
		`CHK("oc_latch", 1'b1, rd[3]);
		// Speed pairs: fast, on target, slow; model outcomes from the period, the last duty also from the previous duty and the phase.
		for (int k = 0; k < 3; k++) begin
			p = per_q[k];
			wait_for(40000, 1);
			ph = ref_n % 512;
			wait_for(2000, 1);
			if (k < 2) per <= 12'(per_q[k + 1]);
			repeat (4) @(posedge mclk_i);
			`CHK("lock", (p >= 480 && p <= 544), loe);
			`CHK("lock_pin", 1'b0, lflag);
			if (p != 512) `CHK("disc", (p > 512), disc);
			ahb(1'b0, bldcsl_pkg::REG_PERIOD, 32'h0);
			`CHK("period", 1'b1, (rd[11:0] >= p - 1 && rd[11:0] <= p + 1));
			ahb(1'b0, bldcsl_pkg::REG_STATUS, 32'h0);
			`CHK("trip", 1'b1, rd[2]);
			`CHK("lo_off", 3'h0, drv.lo);
			ahb(1'b0, bldcsl_pkg::REG_DUTY, 32'h0);
			if (k == 0) `CHK("duty_dn", 8'h7C, rd[7:0]);
			// The capture edge of the last pair still sees a locked loop, so the phase trim acts there once.
			if (k == 2) `CHK("duty_up", 8'(d_prev + 4 + (ph >= 256 ? -1 : 1)), rd[7:0]);
			d_prev = int'(rd[7:0]);
		end
		ahb(1'b1, bldcsl_pkg::REG_CTRL, 32'h00000400);
		ahb(1'b1, bldcsl_pkg::REG_CTRL, 32'h00000401);
		ahb(1'b0, bldcsl_pkg::REG_STATUS, 32'h0);
		`CHK("trip_clr", 1'b0, rd[2]);
		results();
	end
endmodule : tb_top
`default_nettype wire
